// [design/pmsc_top.sv]
// Per-port start-up configuration: strap latching, control-mode selection,
// management write gating and line mode decision for both ports.
// Assumes all pins are synchronous to clock; the negotiation engine itself lives outside.
//
// Functional notes
// - Write-block pin high selects manual mode.
// - Write-block pin low selects management mode.
// - Management mode: straps load, then software controls.
// - Manual mode ignores management register writes.
// - Manual mode sets registers from straps in reset.
// - Reset low, sleep low: latch strap defaults.
// - Sleep high holds port in reset state.
// - Registers decide line mode after reset, link-down.
// - Forced twisted-pair mode starts at once.
// - Negotiation enabled starts negotiation process.
// - Media low: fiber 100, no negotiation.
// - Negotiate, rate, duplex high: advertise all four.
// - Rate high, duplex low: advertise 100 only.
// - Rate low, duplex high: advertise 10 only.
// - Rate, duplex low: advertise half duplex only.
// - Negotiate low: forced speed and duplex straps.
// - Straps set control and advertisement defaults.
`timescale 1ns/10ps
module pmsc_top (
  input  wire logic                                               clock,
  input  wire logic                                               reset,
  input  wire logic                                               clock_en,
  input  wire logic                                               hw_reset_n_pin,
  input  wire logic                                               sleep_pin,
  input  wire logic [pmsc_pkg::NUM_PORTS-1:0]                     mgmt_write_block_pin,
  input  wire logic [pmsc_pkg::NUM_PORTS-1:0]                     media_select_strap,
  input  wire logic [pmsc_pkg::NUM_PORTS-1:0]                     negotiate_strap,
  input  wire logic [pmsc_pkg::NUM_PORTS-1:0]                     rate_select_strap,
  input  wire logic [pmsc_pkg::NUM_PORTS-1:0]                     both_way_strap,
  input  wire logic [pmsc_pkg::NUM_PORTS-1:0]                     link_down,
  input  wire logic                                               mgmt_wr_valid,
  input  wire logic                                               mgmt_wr_port,
  input  wire logic [pmsc_pkg::ADDR_W-1:0]                        mgmt_wr_addr,
  input  wire logic [pmsc_pkg::REG_W-1:0]                         mgmt_wr_data,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          manual_mode,
  output logic [pmsc_pkg::NUM_PORTS-1:0][pmsc_pkg::REG_W-1:0]     ctrl_reg,
  output logic [pmsc_pkg::NUM_PORTS-1:0][pmsc_pkg::REG_W-1:0]     adv_reg,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          line_up,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          line_fiber,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          line_fast,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          line_full,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          an_start,
  output logic [pmsc_pkg::NUM_PORTS-1:0]                          mgmt_wr_ignored
);

  localparam int NP = pmsc_pkg::NUM_PORTS;
  localparam int RW = pmsc_pkg::REG_W;

  // Whole block state in one record
  typedef struct packed {
    pmsc_pkg::pmsc_state_t [NP-1:0] st;
    logic [NP-1:0][RW-1:0]          ctrl;
    logic [NP-1:0][RW-1:0]          adv;
    logic [NP-1:0]                  manual;
    logic [NP-1:0]                  fiber;
    logic [NP-1:0]                  up;
    logic [NP-1:0]                  fast;
    logic [NP-1:0]                  full;
    logic [NP-1:0]                  an_go;
    logic [NP-1:0]                  wr_ign;
  } pmsc_regs_t;

  localparam pmsc_regs_t PMSC_RST = '{st: '{NP{pmsc_pkg::ST_SLEEP}}, default: '0};

  pmsc_regs_t                 state_q;
  pmsc_regs_t                 state_d;
  logic [NP-1:0][RW-1:0]      ctrl_default;
  logic [NP-1:0][RW-1:0]      adv_default;
  logic [NP-1:0]              port_sel;
  logic                       addr_ctrl;
  logic                       addr_adv;

  // One decoder per port so neither port sees the other's straps
  for (genvar p = 0; p < NP; p++)
  begin : g_dec
    pmsc_strap_decode u_dec (
      .media_select_strap (media_select_strap[p]),
      .negotiate_strap    (negotiate_strap[p]),
      .rate_select_strap  (rate_select_strap[p]),
      .both_way_strap     (both_way_strap[p]),
      .ctrl_default       (ctrl_default[p]),
      .adv_default        (adv_default[p])
    );
    assign port_sel[p] = mgmt_wr_valid && (mgmt_wr_port == 1'(p));
  end

  // Write address decode; other addresses belong to other logic
  assign addr_ctrl = (mgmt_wr_addr == pmsc_pkg::CTRL_ADDR);
  assign addr_adv  = (mgmt_wr_addr == pmsc_pkg::ADV_ADDR);

  // Next-state logic for both ports
  always_comb
  begin
    state_d = state_q;
    for (int p = 0; p < NP; p++)
    begin
      state_d.manual[p] = mgmt_write_block_pin[p];
      state_d.an_go[p]  = 1'b0;
      state_d.wr_ign[p] = 1'b0;
      if (sleep_pin)
      begin
        // Sleep doubles as reset and overrides every other pin but the write-block pin, which still sets the mode, and the straps, which still latch
        state_d.st[p]    = pmsc_pkg::ST_SLEEP;
        state_d.ctrl[p]  = ctrl_default[p];
        state_d.adv[p]   = adv_default[p];
        state_d.fiber[p] = ~media_select_strap[p];
        state_d.up[p]    = 1'b0;
      end
      else if (!hw_reset_n_pin)
      begin
        // Straps latched continuously while reset is held, in either mode
        state_d.st[p]    = pmsc_pkg::ST_LATCH;
        state_d.ctrl[p]  = ctrl_default[p];
        state_d.adv[p]   = adv_default[p];
        state_d.fiber[p] = ~media_select_strap[p];
        state_d.up[p]    = 1'b0;
      end
      else
      begin
        case (state_q.st[p])
          pmsc_pkg::ST_SLEEP,
          pmsc_pkg::ST_LATCH:
          begin
            state_d.st[p] = pmsc_pkg::ST_DECIDE;
          end
          pmsc_pkg::ST_DECIDE:
          begin
            state_d.up[p]   = 1'b1;
            state_d.fast[p] = state_q.ctrl[p][pmsc_pkg::CTRL_SPEED_BIT];
            state_d.full[p] = state_q.ctrl[p][pmsc_pkg::CTRL_DUPLEX_BIT];
            if (state_q.fiber[p])
            begin
              state_d.st[p]   = pmsc_pkg::ST_FORCED;
              state_d.fast[p] = 1'b1;
            end
            else if (state_q.ctrl[p][pmsc_pkg::CTRL_AN_BIT])
            begin
              state_d.st[p]    = pmsc_pkg::ST_NEGOTIATE;
              state_d.an_go[p] = 1'b1;
            end
            else
            begin
              state_d.st[p] = pmsc_pkg::ST_FORCED;
            end
          end
          pmsc_pkg::ST_FORCED,
          pmsc_pkg::ST_NEGOTIATE:
          begin
            if (link_down[p])
            begin
              state_d.st[p] = pmsc_pkg::ST_DECIDE;
              state_d.up[p] = 1'b0;
            end
          end
          default:
          begin
            state_d.st[p] = pmsc_pkg::ST_DECIDE;
            state_d.up[p] = 1'b0;
          end
        endcase
        // Writes are only meaningful once the port is out of reset
        if (port_sel[p] && (addr_ctrl || addr_adv)
            && !(state_q.st[p] inside {pmsc_pkg::ST_SLEEP, pmsc_pkg::ST_LATCH}))
        begin
          if (state_q.manual[p])
          begin
            state_d.wr_ign[p] = 1'b1;
          end
          else if (addr_ctrl)
          begin
            // Reset and restart bits read back as zero after acting
            state_d.ctrl[p] = mgmt_wr_data & pmsc_pkg::CTRL_SELFCLR_MASK;
            state_d.st[p]   = pmsc_pkg::ST_DECIDE;
            state_d.up[p]   = 1'b0;
            state_d.an_go[p] = 1'b0;
          end
          else
          begin
            state_d.adv[p] = mgmt_wr_data;
          end
        end
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= PMSC_RST;
    end
    else if (clock_en)
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state record
  assign manual_mode     = state_q.manual;
  assign ctrl_reg        = state_q.ctrl;
  assign adv_reg         = state_q.adv;
  assign line_up         = state_q.up;
  assign line_fiber      = state_q.fiber;
  assign line_fast       = state_q.fast;
  assign line_full       = state_q.full;
  assign an_start        = state_q.an_go;
  assign mgmt_wr_ignored = state_q.wr_ign;

  // Checks, one set per port
  for (genvar p = 0; p < NP; p++)
  begin : g_chk

    mode_pin_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en |=> (manual_mode[p] == $past(mgmt_write_block_pin[p]))
    ) else $error("control mode does not follow write-block pin");

    wr_ignored_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && hw_reset_n_pin && !sleep_pin && manual_mode[p] && port_sel[p] && (addr_ctrl || addr_adv)
      && (state_q.st[p] inside {pmsc_pkg::ST_DECIDE, pmsc_pkg::ST_FORCED, pmsc_pkg::ST_NEGOTIATE})
      |=> mgmt_wr_ignored[p] && $stable(ctrl_reg[p]) && $stable(adv_reg[p])
    ) else $error("manual mode write was not ignored");

    wr_taken_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && hw_reset_n_pin && !sleep_pin && !manual_mode[p] && port_sel[p] && addr_ctrl
      && (state_q.st[p] inside {pmsc_pkg::ST_DECIDE, pmsc_pkg::ST_FORCED, pmsc_pkg::ST_NEGOTIATE})
      |=> (ctrl_reg[p] == ($past(mgmt_wr_data) & pmsc_pkg::CTRL_SELFCLR_MASK))
          && (state_q.st[p] == pmsc_pkg::ST_DECIDE) && !mgmt_wr_ignored[p]
    ) else $error("management control write not stored");

    latch_dflt_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && !sleep_pin && !hw_reset_n_pin
      |=> (ctrl_reg[p] == $past(ctrl_default[p])) && (adv_reg[p] == $past(adv_default[p]))
          && (state_q.st[p] == pmsc_pkg::ST_LATCH) && !line_up[p]
    ) else $error("strap defaults not latched during reset");

    sleep_hold_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && sleep_pin |=> (state_q.st[p] == pmsc_pkg::ST_SLEEP) && !line_up[p] && !an_start[p]
    ) else $error("sleep pin did not hold port in reset");

    redecide_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && hw_reset_n_pin && !sleep_pin && link_down[p] && !port_sel[p]
      && (state_q.st[p] inside {pmsc_pkg::ST_FORCED, pmsc_pkg::ST_NEGOTIATE})
      |=> (state_q.st[p] == pmsc_pkg::ST_DECIDE) && !line_up[p]
    ) else $error("link-down did not return to decision");

    forced_tp_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && hw_reset_n_pin && !sleep_pin && !port_sel[p] && (state_q.st[p] == pmsc_pkg::ST_DECIDE)
      && !state_q.fiber[p] && !ctrl_reg[p][pmsc_pkg::CTRL_AN_BIT]
      |=> (state_q.st[p] == pmsc_pkg::ST_FORCED) && line_up[p] && !an_start[p]
          && (line_fast[p] == $past(ctrl_reg[p][pmsc_pkg::CTRL_SPEED_BIT]))
          && (line_full[p] == $past(ctrl_reg[p][pmsc_pkg::CTRL_DUPLEX_BIT]))
    ) else $error("forced twisted-pair mode not applied");

    nego_go_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && hw_reset_n_pin && !sleep_pin && !port_sel[p] && (state_q.st[p] == pmsc_pkg::ST_DECIDE)
      && !state_q.fiber[p] && ctrl_reg[p][pmsc_pkg::CTRL_AN_BIT]
      |=> an_start[p] && (state_q.st[p] == pmsc_pkg::ST_NEGOTIATE) ##1 (!$past(clock_en) || !an_start[p])
    ) else $error("negotiation not started as one pulse");

    fiber_mode_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && !sleep_pin && !hw_reset_n_pin && !media_select_strap[p]
      |=> line_fiber[p] && !ctrl_reg[p][pmsc_pkg::CTRL_AN_BIT]
          && ctrl_reg[p][pmsc_pkg::CTRL_SPEED_BIT]
          && (ctrl_reg[p][pmsc_pkg::CTRL_DUPLEX_BIT] == $past(both_way_strap[p]))
    ) else $error("fiber strap defaults wrong");

    adv_all_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && !sleep_pin && !hw_reset_n_pin && media_select_strap[p] && negotiate_strap[p]
      && rate_select_strap[p] && both_way_strap[p]
      |=> (adv_reg[p][pmsc_pkg::ADV_ABIL_LSB +: pmsc_pkg::ADV_ABIL_W] == 4'hF) && ctrl_reg[p][pmsc_pkg::CTRL_AN_BIT]
    ) else $error("full advertisement default wrong");

    adv_half_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && !sleep_pin && !hw_reset_n_pin && media_select_strap[p] && negotiate_strap[p]
      && !rate_select_strap[p] && !both_way_strap[p]
      |=> (adv_reg[p][pmsc_pkg::ADV_ABIL_LSB +: pmsc_pkg::ADV_ABIL_W] == 4'h5)
    ) else $error("half duplex advertisement default wrong");

    forced_dflt_a: assert property (
      @(posedge clock) disable iff (reset)
      clock_en && !sleep_pin && !hw_reset_n_pin && media_select_strap[p] && !negotiate_strap[p]
      |=> !ctrl_reg[p][pmsc_pkg::CTRL_AN_BIT]
          && (ctrl_reg[p][pmsc_pkg::CTRL_SPEED_BIT] == $past(rate_select_strap[p]))
          && (ctrl_reg[p][pmsc_pkg::CTRL_DUPLEX_BIT] == $past(both_way_strap[p]))
    ) else $error("forced strap defaults wrong");

  end

endmodule

// [design/pmsc_pkg.sv]
// Shared constants and types for the per-port strap and mode configuration block.
// Assumes a two-port transceiver with 16-bit management registers at addresses 0 and 4.
package pmsc_pkg;

  // Port count and register geometry
  localparam int NUM_PORTS = 2;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 5;

  // Management register addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] ADV_ADDR  = 5'h04;

  // Control register field positions
  localparam int CTRL_RESET_BIT   = 15;
  localparam int CTRL_SPEED_BIT   = 13;
  localparam int CTRL_AN_BIT      = 12;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;

  // Mask of bits kept after a write; its zero bits clear themselves
  localparam logic [REG_W-1:0] CTRL_SELFCLR_MASK = 16'h7DFF;

  // Control register reset value before strap fields are merged in
  localparam logic [REG_W-1:0] CTRL_BASE = 16'h0000;

  // Advertisement register: ability field sits in bits 8 down to 5
  localparam int ADV_ABIL_LSB = 5;
  localparam int ADV_ABIL_W   = 4;
  localparam logic [REG_W-1:0] ADV_SELECTOR = 16'h0001;

  // Ability nibbles, bit 3 = 100 full, 2 = 100 half, 1 = 10 full, 0 = 10 half
  localparam logic [ADV_ABIL_W-1:0] ABIL_ALL   = 4'hF;
  localparam logic [ADV_ABIL_W-1:0] ABIL_100   = 4'hC;
  localparam logic [ADV_ABIL_W-1:0] ABIL_10    = 4'h3;
  localparam logic [ADV_ABIL_W-1:0] ABIL_HALF  = 4'h5;
  localparam logic [ADV_ABIL_W-1:0] ABIL_NONE  = 4'h0;

  // Per-port line bring-up states
  typedef enum logic [4:0] {
    ST_SLEEP     = 5'h01,
    ST_LATCH     = 5'h02,
    ST_DECIDE    = 5'h04,
    ST_FORCED    = 5'h08,
    ST_NEGOTIATE = 5'h10
  } pmsc_state_t;

endpackage

// [design/pmsc_strap_decode.sv]
// Strap decoder: turns one port's four strap pins into register defaults.
// Assumes the straps are steady while they are being latched; purely combinational.
`timescale 1ns/10ps
module pmsc_strap_decode (
  input  wire logic                    media_select_strap,
  input  wire logic                    negotiate_strap,
  input  wire logic                    rate_select_strap,
  input  wire logic                    both_way_strap,
  output logic [pmsc_pkg::REG_W-1:0]   ctrl_default,
  output logic [pmsc_pkg::REG_W-1:0]   adv_default
);

  logic [pmsc_pkg::ADV_ABIL_W-1:0] abil;
  logic                            twisted;
  logic                            nego;

  // Low media strap means fiber, which never negotiates
  assign twisted = media_select_strap;
  assign nego    = twisted & negotiate_strap;

  // Ability nibble chosen by rate and duplex straps
  always_comb
  begin
    abil = pmsc_pkg::ABIL_NONE;
    if (nego)
    begin
      case ({rate_select_strap, both_way_strap})
        2'b11:   abil = pmsc_pkg::ABIL_ALL;
        2'b10:   abil = pmsc_pkg::ABIL_100;
        2'b01:   abil = pmsc_pkg::ABIL_10;
        2'b00:   abil = pmsc_pkg::ABIL_HALF;
        default: abil = pmsc_pkg::ABIL_NONE;
      endcase
    end
  end

  // Control defaults: fiber is 100 Mbps forced, twisted pair follows the rate strap
  always_comb
  begin
    ctrl_default = pmsc_pkg::CTRL_BASE;
    ctrl_default[pmsc_pkg::CTRL_SPEED_BIT]  = twisted ? rate_select_strap : 1'b1;
    ctrl_default[pmsc_pkg::CTRL_AN_BIT]     = nego;
    ctrl_default[pmsc_pkg::CTRL_DUPLEX_BIT] = both_way_strap;
  end

  // Advertisement defaults; forced modes advertise nothing
  always_comb
  begin
    adv_default = pmsc_pkg::ADV_SELECTOR;
    adv_default[pmsc_pkg::ADV_ABIL_LSB +: pmsc_pkg::ADV_ABIL_W] = abil;
  end

endmodule

// [bench/pmsc_mgmt_model.sv]
// Station management writer model: issues single register write strobes to the block.
// Assumes the bench calls its write task; every change lands just after a rising edge.
`timescale 1ns/10ps
module pmsc_mgmt_model (
  input  wire logic                        clock,
  output logic                             mgmt_wr_valid,
  output logic                             mgmt_wr_port,
  output logic [pmsc_pkg::ADDR_W-1:0]      mgmt_wr_addr,
  output logic [pmsc_pkg::REG_W-1:0]       mgmt_wr_data
);
  // Idle bus at time zero
  initial
  begin
    mgmt_wr_valid = 1'b0;
    mgmt_wr_port  = 1'b0;
    mgmt_wr_addr  = 5'h1F;
    mgmt_wr_data  = 16'hA5A5;
  end

  // One write, after gap idle cycles; strobe and qualifiers hold through the taking edge.
  // Released qualifiers are flipped so a stale value never looks like a fresh write.
  task automatic write(input int gap, input logic port, input logic [pmsc_pkg::ADDR_W-1:0] addr,
                       input logic [pmsc_pkg::REG_W-1:0] data);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    mgmt_wr_valid <= 1'b1;
    mgmt_wr_port  <= port;
    mgmt_wr_addr  <= addr;
    mgmt_wr_data  <= data;
    @(posedge clock);
    mgmt_wr_valid <= 1'b0;
    mgmt_wr_port  <= ~port;
    mgmt_wr_addr  <= ~addr;
    mgmt_wr_data  <= ~data;
  endtask
endmodule

// [bench/phy_port_mode_strap_config_test.sv]
// Self-checking bench for the per-port strap and mode configuration block.
// Assumes pmsc_pkg and the design compile first; writes come from the management model.
`timescale 1ns/10ps
module phy_port_mode_strap_config_test;
  logic                                           clock;
  logic                                           reset;
  logic                                           clock_en;
  logic                                           hw_reset_n_pin;
  logic                                           sleep_pin;
  logic [1:0]                                     mgmt_write_block_pin;
  logic [1:0]                                     media_select_strap;
  logic [1:0]                                     negotiate_strap;
  logic [1:0]                                     rate_select_strap;
  logic [1:0]                                     both_way_strap;
  logic [1:0]                                     link_down;
  logic                                           mgmt_wr_valid;
  logic                                           mgmt_wr_port;
  logic [pmsc_pkg::ADDR_W-1:0]                    mgmt_wr_addr;
  logic [pmsc_pkg::REG_W-1:0]                     mgmt_wr_data;
  logic [1:0]                                     manual_mode;
  logic [1:0][pmsc_pkg::REG_W-1:0]                ctrl_reg;
  logic [1:0][pmsc_pkg::REG_W-1:0]                adv_reg;
  logic [1:0]                                     line_up;
  logic [1:0]                                     line_fiber;
  logic [1:0]                                     line_fast;
  logic [1:0]                                     line_full;
  logic [1:0]                                     an_start;
  logic [1:0]                                     mgmt_wr_ignored;
  int                                             error_cnt;
  int                                             check_count;
  int                                             cyc;

  pmsc_mgmt_model u_mgmt (.clock(clock), .mgmt_wr_valid(mgmt_wr_valid), .mgmt_wr_port(mgmt_wr_port),
                          .mgmt_wr_addr(mgmt_wr_addr), .mgmt_wr_data(mgmt_wr_data));

  pmsc_top u_dut (.clock(clock), .reset(reset), .clock_en(clock_en), .hw_reset_n_pin(hw_reset_n_pin),
                  .sleep_pin(sleep_pin), .mgmt_write_block_pin(mgmt_write_block_pin),
                  .media_select_strap(media_select_strap), .negotiate_strap(negotiate_strap),
                  .rate_select_strap(rate_select_strap), .both_way_strap(both_way_strap),
                  .link_down(link_down), .mgmt_wr_valid(mgmt_wr_valid), .mgmt_wr_port(mgmt_wr_port),
                  .mgmt_wr_addr(mgmt_wr_addr), .mgmt_wr_data(mgmt_wr_data), .manual_mode(manual_mode),
                  .ctrl_reg(ctrl_reg), .adv_reg(adv_reg), .line_up(line_up), .line_fiber(line_fiber),
                  .line_fast(line_fast), .line_full(line_full), .an_start(an_start),
                  .mgmt_wr_ignored(mgmt_wr_ignored));

  // 10 MHz clock
  always #50 clock = ~clock;

  // Hang guard; the whole run needs under two hundred cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  // Expected control default; strap word is {media, negotiate, rate, duplex}
  function automatic logic [15:0] exp_ctrl(input logic [3:0] s);
    logic [15:0] v;
    v = 16'h0000;
    v[pmsc_pkg::CTRL_SPEED_BIT]  = s[3] ? s[1] : 1'b1;
    v[pmsc_pkg::CTRL_AN_BIT]     = s[3] & s[2];
    v[pmsc_pkg::CTRL_DUPLEX_BIT] = s[0];
    return v;
  endfunction

  // Expected advertisement default: abilities only when negotiating on twisted pair
  function automatic logic [15:0] exp_adv(input logic [3:0] s);
    logic [3:0] n;
    n = 4'h0;
    if (s[3] && s[2])
      n = s[1] ? (s[0] ? 4'hF : 4'hC) : (s[0] ? 4'h3 : 4'h5);
    return {7'h00, n, 5'h01};
  endfunction

  // Compare tasks, one per kind of result
  task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_vec(input string name, input logic [1:0] exp, input logic [1:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Latch straps under the reset pin, then release it and check the chosen line mode
  task automatic run_straps(input logic [3:0] s0, input logic [3:0] s1, input logic [1:0] blk);
    logic [15:0] c0;
    logic [15:0] c1;
    c0 = exp_ctrl(s0);
    c1 = exp_ctrl(s1);
    @(posedge clock);
    media_select_strap   <= {s1[3], s0[3]};
    negotiate_strap      <= {s1[2], s0[2]};
    rate_select_strap    <= {s1[1], s0[1]};
    both_way_strap       <= {s1[0], s0[0]};
    mgmt_write_block_pin <= blk;
    hw_reset_n_pin       <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk_vec("manual_mode", blk, manual_mode);
    chk_reg("ctrl0", c0, ctrl_reg[0]);
    chk_reg("ctrl1", c1, ctrl_reg[1]);
    chk_reg("adv0", exp_adv(s0), adv_reg[0]);
    chk_reg("adv1", exp_adv(s1), adv_reg[1]);
    @(posedge clock);
    hw_reset_n_pin <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk_vec("line_up", 2'b11, line_up);
    chk_vec("line_fiber", ~{s1[3], s0[3]}, line_fiber);
    chk_vec("line_fast", {c1[13], c0[13]}, line_fast);
    chk_vec("line_full", {c1[8], c0[8]}, line_full);
    chk_vec("an_start", {c1[12], c0[12]}, an_start);
  endtask

  // Every strap combination, the other port inverted and the mode pins mixed
  task automatic t_straps();
    logic [3:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = i[3:0];
      run_straps(v, ~v, {~v[1], v[1]});
    end
    $display("test straps done");
  endtask

  // Management writes: accepted on port 0, refused on manual port 1, unmapped dropped
  task automatic t_write();
    run_straps(4'b1011, 4'b1111, 2'b10);
    u_mgmt.write(0, 1'b0, 5'h00, 16'h9200);
    #1;
    chk_reg("ctrl0", 16'h1000, ctrl_reg[0]);
    chk_vec("line_up", 2'b10, line_up);
    @(posedge clock);
    #1;
    chk_vec("an_start", 2'b01, an_start);
    chk_vec("line_up", 2'b11, line_up);
    u_mgmt.write(1, 1'b1, 5'h00, 16'h0000);
    #1;
    chk_vec("ignored", 2'b10, mgmt_wr_ignored);
    chk_reg("ctrl1", exp_ctrl(4'b1111), ctrl_reg[1]);
    @(posedge clock);
    #1;
    chk_vec("ignored", 2'b00, mgmt_wr_ignored);
    u_mgmt.write(2, 1'b0, 5'h04, 16'h01E1);
    #1;
    chk_reg("adv0", 16'h01E1, adv_reg[0]);
    u_mgmt.write(0, 1'b0, 5'h02, 16'hFFFF);
    #1;
    chk_reg("ctrl0", 16'h1000, ctrl_reg[0]);
    chk_vec("ignored", 2'b00, mgmt_wr_ignored);
    $display("test write done");
  endtask

  // Link-down on port 0 forces a fresh decision; port 1 keeps running
  task automatic t_link();
    @(posedge clock);
    link_down <= 2'b01;
    @(posedge clock);
    link_down <= 2'b00;
    #1;
    chk_vec("line_up", 2'b10, line_up);
    @(posedge clock);
    #1;
    chk_vec("line_up", 2'b11, line_up);
    chk_vec("an_start", 2'b01, an_start);
    $display("test link done");
  endtask

  // Sleep acts as reset even with the reset pin high, and latches new straps
  task automatic t_sleep();
    @(posedge clock);
    sleep_pin             <= 1'b1;
    media_select_strap[0] <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_vec("line_up", 2'b00, line_up);
    chk_reg("ctrl0", exp_ctrl(4'b0011), ctrl_reg[0]);
    @(posedge clock);
    sleep_pin <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_vec("line_up", 2'b11, line_up);
    chk_vec("line_fiber", 2'b01, line_fiber);
    chk_vec("line_full", 2'b11, line_full);
    $display("test sleep done");
  endtask

  // Clock enable low freezes state and loses a strobe; a write on the first edge out of reset is dropped
  task automatic t_hold();
    @(posedge clock);
    clock_en  <= 1'b0;
    link_down <= 2'b11;
    u_mgmt.write(0, 1'b0, 5'h00, 16'h0000);
    link_down <= 2'b00;
    #1;
    chk_vec("line_up", 2'b11, line_up);
    chk_reg("ctrl0", exp_ctrl(4'b0011), ctrl_reg[0]);
    @(posedge clock);
    clock_en <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk_vec("line_up", 2'b11, line_up);
    chk_reg("ctrl0", exp_ctrl(4'b0011), ctrl_reg[0]);
    @(posedge clock);
    hw_reset_n_pin <= 1'b0;
    fork
      begin
        @(posedge clock);
        hw_reset_n_pin <= 1'b1;
      end
      u_mgmt.write(0, 1'b0, 5'h04, 16'h0000);
    join
    #1;
    chk_reg("adv0", exp_adv(4'b0011), adv_reg[0]);
    chk_vec("ignored", 2'b00, mgmt_wr_ignored);
    repeat (2) @(posedge clock);
    #1;
    chk_vec("line_up", 2'b11, line_up);
    $display("test hold done");
  endtask

  // Counts and verdict; the single end of the run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clock                = 1'b0;
    reset                = 1'b1;
    clock_en             = 1'b1;
    hw_reset_n_pin       = 1'b0;
    sleep_pin            = 1'b0;
    mgmt_write_block_pin = 2'b00;
    media_select_strap   = 2'b11;
    negotiate_strap      = 2'b11;
    rate_select_strap    = 2'b11;
    both_way_strap       = 2'b11;
    link_down            = 2'b00;
    error_cnt            = 0;
    check_count          = 0;
    cyc                  = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_straps();
    t_write();
    t_link();
    t_sleep();
    t_hold();
    finish_test();
  end
endmodule
